/* File: include/lp_pkg.sv */
// shared constants and types for the low-power mode controller and its cpu-side port
package lp_pkg;

  // ==========================================================================
  // pins and register index map on the link
  // ==========================================================================
  localparam int          IRQ_LINES     = 16;
  localparam int          PIN_W         = 19;
  localparam int          PIN_NMI       = 16;
  localparam int          PIN_INIT      = 17;
  localparam int          PIN_HWSTBY    = 18;
  localparam int          REG_IDX_W     = 3;
  localparam logic [2:0]  IDX_HW_STANDBY_PIN_CTRL = 3'h0;
  localparam logic [2:0]  IDX_WAKE_SRC  = 3'h1;
  localparam logic [2:0]  IDX_HALT      = 3'h2;
  localparam logic [2:0]  IDX_EXT_HALT  = 3'h3;
  localparam logic [2:0]  IDX_DIVIDER   = 3'h4;

  // ==========================================================================
  // fields and reset values
  // ==========================================================================
  localparam int          HW_STANDBY_PIN_SEL_BIT  = 7;
  localparam int          BUS_KEEP_BIT  = 6;
  localparam int          SETTLE_SEL_LO = 0;
  localparam int          WAKE_EN_BIT   = 0;
  localparam int          HALT_DMA_BIT  = 13;
  localparam int          HALT_DTC_BIT  = 14;
  localparam int          EXT_DMA_BIT   = 0;
  localparam int          BUSY_EXT_DMA  = 0;
  localparam int          BUSY_DMA      = 1;
  localparam int          BUSY_DTC      = 2;
  localparam logic [7:0]  HW_STANDBY_PIN_CTRL_RST = 8'h40;
  localparam logic [15:0] HALT_RST      = 16'h0000;
  localparam logic [7:0]  EXT_HALT_RST  = 8'h00;
  localparam logic [2:0]  DIV_RST       = 3'h0;
  localparam logic [2:0]  DIV_SEL_MAX   = 3'h5;

  // ==========================================================================
  // timing: reset width in divided-clock ticks, settle shift cap, clock rates in MHz
  // ==========================================================================
  localparam logic [15:0] RESET_MIN_TICKS  = 16'h0014;
  localparam logic [3:0]  SETTLE_MAX_SHIFT = 4'ha;
  localparam int          SRC_CLOCK_MHZ    = 32;
  localparam int          MIN_SYS_MHZ      = 8;

  // ==========================================================================
  // cpu-side avalon map (byte addresses)
  // ==========================================================================
  localparam int          AV_ADDR_W     = 6;
  localparam logic [5:0]  AV_IRQ_ENABLE = 6'h14;
  localparam logic [5:0]  AV_SLEEP_CMD  = 6'h18;
  localparam logic [5:0]  AV_STATUS     = 6'h1c;
  localparam logic [5:0]  AV_DEV_LIMIT  = 6'h14;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STANDBY,
    ST_SETTLE,
    ST_INIT,
    ST_HWSTBY
  } lp_mode_e;

endpackage : lp_pkg

/* File: include/lp_link_if.sv */
// link between the cpu-side port and the low-power mode controller
`timescale 1ns/100ps
interface lp_link_if;
  import lp_pkg::*;

  logic                 sleep_req;       // sleep instruction executed, one cycle
  logic                 reg_wr;          // register write strobe, one cycle
  logic [REG_IDX_W-1:0] reg_addr;        // register index
  logic [15:0]          reg_wdata;       // write data
  logic [15:0]          reg_rdata;       // read data, one cycle after reg_addr
  logic [IRQ_LINES-1:0] irq_enable;      // per-line interrupt enable
  logic                 cpu_int_masked;  // cpu masks all but nmi
  lp_mode_e             mode;            // controller state

  modport dev (
    input  sleep_req, reg_wr, reg_addr, reg_wdata, irq_enable, cpu_int_masked,
    output reg_rdata, mode
  );

  modport cpu (
    output sleep_req, reg_wr, reg_addr, reg_wdata, irq_enable, cpu_int_masked,
    input  reg_rdata, mode
  );

endinterface : lp_link_if

/* File: core/lp_device.sv */
// low-power mode controller: sleep, software standby, hardware standby and wake sequencing
`timescale 1ns/100ps
module lp_device #(
  parameter logic [15:0] SETTLE_BASE_TICKS = 16'h0020
) (
  input  wire logic                          clock,                 // 250 MHz clock
  input  wire logic                          reset,                 // synchronous, active high
  lp_link_if.dev                             link,                  // cpu-side link
  input  wire logic [lp_pkg::IRQ_LINES-1:0]  external_int_lines_n,  // external interrupt pins, low active
  input  wire logic                          nmi_pin_n,             // non-maskable interrupt pin
  input  wire logic                          external_init_pin_n,   // external init pin, low active
  input  wire logic                          hw_standby_pin_n,      // hardware standby pin, low active
  input  wire logic                          periph_irq,            // enabled on-chip interrupt request
  input  wire logic [2:0]                    module_busy,           // ext dma, dma, transfer unit busy
  output logic                               cpu_halt,              // cpu stopped, registers kept
  output logic                               periph_run,            // on-chip peripherals clocked
  output logic                               phi_tick,              // divided system clock tick
  output logic                               osc_run,               // oscillator enabled
  output logic                               clock_stable,          // clocks supplied device-wide
  output logic                               bus_hiz,               // address and bus control float
  output logic                               bus_hold,              // address and bus control held
  output logic                               serial_adc_init,       // serial unit and converter reset
  output logic [15:0]                        module_halt,           // module stop bits
  output logic [7:0]                         ext_module_halt,       // extended module stop bits
  output logic                               chip_reset,            // device held in reset
  output logic                               reset_exception,       // start reset exception, pulse
  output logic                               int_exception          // start interrupt exception, pulse
);
  import lp_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    lp_mode_e         st;
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] pins;
    logic             nmi_prev;
    logic [7:0]       ctrl;
    logic             wake_en;
    logic [15:0]      halt;
    logic [7:0]       ext_halt;
    logic [2:0]       div;
    logic [4:0]       div_cnt;
    logic             tick;
    logic [15:0]      cnt;
    logic [15:0]      rdata;
    logic             reset_exc;
    logic             int_exc;
  } dev_s;

  localparam dev_s DEV_RST = '{
    st:        ST_RUN,
    s1:        '1,
    s2:        '1,
    s3:        '1,
    pins:      '1,
    nmi_prev:  1'b1,
    ctrl:      HW_STANDBY_PIN_CTRL_RST,
    wake_en:   1'b0,
    halt:      HALT_RST,
    ext_halt:  EXT_HALT_RST,
    div:       DIV_RST,
    div_cnt:   5'h00,
    tick:      1'b0,
    cnt:       16'h0000,
    rdata:     16'h0000,
    reset_exc: 1'b0,
    int_exc:   1'b0
  };

  dev_s q;
  dev_s d;

  logic                 nmi_edge;
  logic [IRQ_LINES-1:0] irq_act;
  logic                 sleep_wake;
  logic                 hw_standby_pin_wake;
  logic [4:0]           div_limit;
  logic [3:0]           settle_shift;
  logic [15:0]          settle_ticks;
  logic [15:0]          halt_lock;
  logic [7:0]           ext_lock;
  logic                 in_hw_standby_pin;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb
  begin
    d = q;

    // pins: a change counts once the second and third stage agree
    d.s1       = {hw_standby_pin_n, external_init_pin_n, nmi_pin_n, external_int_lines_n};
    d.s2       = q.s1;
    d.s3       = q.s2;
    d.pins     = (q.s2 & q.s3) | (q.pins & (q.s2 | q.s3));
    d.nmi_prev = q.pins[PIN_NMI];

    // divided system clock; every wait below counts these ticks
    div_limit = 5'((6'h01 << q.div) - 6'h01);
    d.tick    = 1'b0;
    if (q.div_cnt >= div_limit)
    begin
      d.div_cnt = 5'h00;
      d.tick    = 1'b1;
    end
    else
    begin
      d.div_cnt = q.div_cnt + 5'h01;
    end

    nmi_edge     = q.nmi_prev & ~q.pins[PIN_NMI];
    irq_act      = ~q.pins[IRQ_LINES-1:0] & link.irq_enable;
    sleep_wake   = nmi_edge | (~link.cpu_int_masked & ((|irq_act) | periph_irq));
    hw_standby_pin_wake    = nmi_edge | (q.wake_en & (|irq_act));
    settle_shift = (q.ctrl[SETTLE_SEL_LO +: 4] > SETTLE_MAX_SHIFT) ? SETTLE_MAX_SHIFT
                                                                  : q.ctrl[SETTLE_SEL_LO +: 4];
    settle_ticks = SETTLE_BASE_TICKS << settle_shift;

    d.reset_exc = 1'b0;
    d.int_exc   = 1'b0;

    case (q.st)
      ST_RUN:
      begin
        if (link.sleep_req)
        begin
          d.st = q.ctrl[HW_STANDBY_PIN_SEL_BIT] ? ST_STANDBY : ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (sleep_wake)
        begin
          d.st      = ST_RUN;
          d.int_exc = 1'b1;
        end
      end
      ST_STANDBY:
      begin
        if (hw_standby_pin_wake)
        begin
          d.st  = ST_SETTLE;
          d.cnt = settle_ticks;
        end
      end
      ST_SETTLE:
      begin
        if (q.tick)
        begin
          if (q.cnt <= 16'h0001)
          begin
            d.st      = ST_RUN;
            d.int_exc = 1'b1;
            d.cnt     = 16'h0000;
          end
          else
          begin
            d.cnt = q.cnt - 16'h0001;
          end
        end
      end
      ST_INIT:
      begin
        // a short pulse is stretched to the least width before the exception
        if (q.tick && q.cnt != 16'h0000)
        begin
          d.cnt = q.cnt - 16'h0001;
        end
        if (q.pins[PIN_INIT] && q.cnt == 16'h0000)
        begin
          d.st        = ST_RUN;
          d.reset_exc = 1'b1;
        end
      end
      ST_HWSTBY:
      begin
        // leaving hardware standby always passes through a full reset
        if (q.pins[PIN_HWSTBY])
        begin
          d.st  = ST_INIT;
          d.cnt = RESET_MIN_TICKS;
        end
      end
      default:
      begin
        d.st = ST_RUN;
      end
    endcase

    if (!q.pins[PIN_INIT] && q.st != ST_INIT && q.st != ST_HWSTBY)
    begin
      d.st      = ST_INIT;
      d.cnt     = RESET_MIN_TICKS;
      d.int_exc = 1'b0;
    end
    if (!q.pins[PIN_HWSTBY])
    begin
      d.st        = ST_HWSTBY;
      d.int_exc   = 1'b0;
      d.reset_exc = 1'b0;
    end

    // register writes; busy transfer units keep their stop bit clear
    halt_lock               = 16'h0000;
    halt_lock[HALT_DMA_BIT] = module_busy[BUSY_DMA] & ~q.halt[HALT_DMA_BIT];
    halt_lock[HALT_DTC_BIT] = module_busy[BUSY_DTC] & ~q.halt[HALT_DTC_BIT];
    ext_lock                = 8'h00;
    ext_lock[EXT_DMA_BIT]   = module_busy[BUSY_EXT_DMA] & ~q.ext_halt[EXT_DMA_BIT];
    if (link.reg_wr && q.st == ST_RUN)
    begin
      case (link.reg_addr)
        IDX_HW_STANDBY_PIN_CTRL: d.ctrl     = link.reg_wdata[7:0];
        IDX_WAKE_SRC:  d.wake_en  = link.reg_wdata[WAKE_EN_BIT];
        IDX_HALT:      d.halt     = (link.reg_wdata & ~halt_lock) | (q.halt & halt_lock);
        IDX_EXT_HALT:  d.ext_halt = (link.reg_wdata[7:0] & ~ext_lock) | (q.ext_halt & ext_lock);
        IDX_DIVIDER:   d.div      = (link.reg_wdata[2:0] > DIV_SEL_MAX) ? DIV_SEL_MAX : link.reg_wdata[2:0];
        default:       d.div      = q.div;
      endcase
    end

    // reset and hardware standby lose all settings
    if (d.st == ST_INIT || d.st == ST_HWSTBY)
    begin
      d.ctrl     = HW_STANDBY_PIN_CTRL_RST;
      d.wake_en  = 1'b0;
      d.halt     = HALT_RST;
      d.ext_halt = EXT_HALT_RST;
      d.div      = DIV_RST;
    end

    case (link.reg_addr)
      IDX_HW_STANDBY_PIN_CTRL: d.rdata = {8'h00, q.ctrl};
      IDX_WAKE_SRC:  d.rdata = {15'h0000, q.wake_en};
      IDX_HALT:      d.rdata = q.halt;
      IDX_EXT_HALT:  d.rdata = {8'h00, q.ext_halt};
      IDX_DIVIDER:   d.rdata = {13'h0000, q.div};
      default:       d.rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      q <= DEV_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  // settings, memory and cpu registers are simply not touched in software standby
  assign in_hw_standby_pin         = (q.st == ST_STANDBY) || (q.st == ST_SETTLE);
  assign cpu_halt        = (q.st != ST_RUN);
  assign periph_run      = (q.st == ST_RUN) || (q.st == ST_SLEEP);
  assign osc_run         = (q.st != ST_STANDBY) && (q.st != ST_HWSTBY);
  assign clock_stable    = !in_hw_standby_pin && (q.st != ST_HWSTBY);
  assign phi_tick        = q.tick & clock_stable;
  assign bus_hiz         = (in_hw_standby_pin && !q.ctrl[BUS_KEEP_BIT]) || (q.st == ST_HWSTBY);
  assign bus_hold        = in_hw_standby_pin && q.ctrl[BUS_KEEP_BIT];
  assign serial_adc_init = in_hw_standby_pin || (q.st == ST_HWSTBY) || (q.st == ST_INIT);
  assign module_halt     = q.halt;
  assign ext_module_halt = q.ext_halt;
  assign chip_reset      = (q.st == ST_INIT) || (q.st == ST_HWSTBY);
  assign reset_exception = q.reset_exc;
  assign int_exception   = q.int_exc;
  assign link.reg_rdata  = q.rdata;
  assign link.mode       = q.st;

endmodule : lp_device

/* File: core/lp_cpu_port.sv */
// cpu-side port: avalon-mm slave that issues sleep and register writes to the controller
`timescale 1ns/100ps
module lp_cpu_port (
  input  wire logic                          clock,             // 250 MHz clock
  input  wire logic                          reset,             // synchronous, active high
  input  wire logic [lp_pkg::AV_ADDR_W-1:0]  address,           // avalon byte address
  input  wire logic                          read,              // avalon read
  input  wire logic                          write,             // avalon write
  input  wire logic [31:0]                   writedata,         // avalon write data
  output logic [31:0]                        readdata,          // avalon read data
  output logic                               waitrequest,       // avalon wait
  input  wire logic                          cpu_int_masked,    // cpu masks non-nmi interrupts
  input  wire logic [15:0]                   module_int_on,     // module interrupts enabled, per stop bit
  input  wire logic [2:0]                    module_busy,       // ext dma, dma, transfer unit busy
  lp_link_if.cpu                             link               // controller link
);
  import lp_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE,
    H_RD1,
    H_RD2,
    H_DONE
  } host_e;

  typedef struct packed {
    host_e                st;
    logic                 wr;
    logic [REG_IDX_W-1:0] addr;
    logic [15:0]          wdata;
    logic                 sleep;
    logic [IRQ_LINES-1:0] irq_en;
    logic                 refused;
    logic [31:0]          rdata;
  } host_s;

  localparam host_s HOST_RST = '{
    st: H_IDLE, wr: 1'b0, addr: '0, wdata: 16'h0000, sleep: 1'b0,
    irq_en: '0, refused: 1'b0, rdata: 32'h0000_0000
  };

  host_s q;
  host_s d;
  logic  refuse;
  logic  dev_hit;

  // ==========================================================================
  // request handling
  // ==========================================================================
  always_comb
  begin
    d       = q;
    d.wr    = 1'b0;
    d.sleep = 1'b0;
    dev_hit = (address < AV_DEV_LIMIT);
    refuse  = 1'b0;
    case (address[4:2])
      IDX_HALT:
      begin
        refuse = |(writedata[15:0] & module_int_on)
               | (writedata[HALT_DMA_BIT] & module_busy[BUSY_DMA])
               | (writedata[HALT_DTC_BIT] & module_busy[BUSY_DTC]);
      end
      IDX_EXT_HALT: refuse = writedata[EXT_DMA_BIT] & module_busy[BUSY_EXT_DMA];
      IDX_DIVIDER:
      begin
        refuse = (writedata[2:0] > DIV_SEL_MAX)
               || ((SRC_CLOCK_MHZ >> writedata[2:0]) < MIN_SYS_MHZ);
      end
      default: refuse = 1'b0;
    endcase

    case (q.st)
      H_IDLE:
      begin
        if (write)
        begin
          d.st = H_DONE;
          if (dev_hit)
          begin
            d.wr      = !refuse;
            d.addr    = address[4:2];
            d.wdata   = writedata[15:0];
            d.refused = q.refused | refuse;
          end
          else if (address == AV_IRQ_ENABLE)
          begin
            d.irq_en = writedata[IRQ_LINES-1:0];
          end
          else if (address == AV_SLEEP_CMD)
          begin
            d.sleep = 1'b1;
          end
        end
        else if (read)
        begin
          d.st    = H_DONE;
          d.rdata = 32'h0000_0000;
          if (dev_hit)
          begin
            d.st   = H_RD1;
            d.addr = address[4:2];
          end
          else if (address == AV_IRQ_ENABLE)
          begin
            d.rdata = {16'h0000, q.irq_en};
          end
          else if (address == AV_STATUS)
          begin
            // reading status clears the refusal flag
            d.rdata   = {28'h0000000, q.refused, link.mode};
            d.refused = 1'b0;
          end
        end
      end
      H_RD1: d.st = H_RD2;
      H_RD2:
      begin
        d.st    = H_DONE;
        d.rdata = {16'h0000, link.reg_rdata};
      end
      H_DONE: d.st = H_IDLE;
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      q <= HOST_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign readdata            = q.rdata;
  assign waitrequest         = (read | write) & (q.st != H_DONE);
  assign link.sleep_req      = q.sleep;
  assign link.reg_wr         = q.wr;
  assign link.reg_addr       = q.addr;
  assign link.reg_wdata      = q.wdata;
  assign link.irq_enable     = q.irq_en;
  assign link.cpu_int_masked = cpu_int_masked;

endmodule : lp_cpu_port

/* File: verification/lp_link_checker.sv */
// link assertions for the low-power mode controller
`timescale 1ns/100ps
module lp_link_checker (
  input wire logic                         clock,          // clock
  input wire logic                         reset,          // reset
  input wire logic                         sleep_req,      // sleep pulse
  input wire logic                         reg_wr,         // write strobe
  input wire logic [lp_pkg::REG_IDX_W-1:0] reg_addr,       // index
  input wire logic [15:0]                  reg_wdata,      // write data
  input wire logic [15:0]                  reg_rdata,      // read data
  input wire logic [lp_pkg::IRQ_LINES-1:0] irq_enable,     // line enables
  input wire logic                         cpu_int_masked, // cpu mask
  input wire lp_pkg::lp_mode_e             mode            // state
);
  import lp_pkg::*;
  // ==========================================================
  // helper state
  // ==========================================================
  logic       sel_q;
  logic [7:0] init_cnt_q;
  // registers return to reset values in init and hw standby
  always_ff @(posedge clock)
    if (reset || mode == ST_INIT || mode == ST_HWSTBY)
      sel_q <= HW_STANDBY_PIN_CTRL_RST[HW_STANDBY_PIN_SEL_BIT];
    else if (reg_wr && reg_addr == IDX_HW_STANDBY_PIN_CTRL && mode == ST_RUN)
      sel_q <= reg_wdata[HW_STANDBY_PIN_SEL_BIT];
  always_ff @(posedge clock)
    if (reset || mode != ST_INIT)
      init_cnt_q <= 8'h00;
    else if (init_cnt_q != 8'hff)
      init_cnt_q <= init_cnt_q + 8'h01;
  // ==========================================================
  // properties
  // ==========================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_slp_cmd;
    mode == ST_RUN && sleep_req && !sel_q;
  endsequence
  sequence s_hw_standby_pin_cmd;
    mode == ST_RUN && sleep_req && sel_q;
  endsequence
  sequence s_settle_in;
    $rose(mode == ST_SETTLE);
  endsequence
  a_run_hold: assert property (mode == ST_RUN && !sleep_req |=> mode inside {ST_RUN, ST_INIT, ST_HWSTBY})
    else $error("run left without sleep request");
  a_sleep_enter: assert property (s_slp_cmd |=> mode inside {ST_SLEEP, ST_INIT, ST_HWSTBY})
    else $error("sleep not entered");
  a_hw_standby_pin_enter: assert property (s_hw_standby_pin_cmd |=> mode inside {ST_STANDBY, ST_INIT, ST_HWSTBY})
    else $error("standby not entered");
  a_sleep_exit: assert property (mode == ST_SLEEP |=> mode != ST_STANDBY && mode != ST_SETTLE)
    else $error("bad exit from sleep");
  a_hw_standby_pin_exit: assert property (mode == ST_STANDBY |=> mode != ST_RUN && mode != ST_SLEEP)
    else $error("standby left without settling");
  a_settle_span: assert property (s_settle_in |-> (mode == ST_SETTLE)[*2] ##[1:1000] mode != ST_SETTLE)
    else $error("settle span wrong");
  a_settle_exit: assert property (mode == ST_SETTLE |=> mode inside {ST_SETTLE, ST_RUN, ST_INIT, ST_HWSTBY})
    else $error("bad exit from settle");
  a_hw_exit: assert property (mode == ST_HWSTBY |=> mode inside {ST_HWSTBY, ST_INIT})
    else $error("hw standby left wrongly");
  // only a release to run is judged; hw standby may cut init short
  a_init_width: assert property ($fell(mode == ST_INIT) && mode == ST_RUN
    |-> init_cnt_q >= RESET_MIN_TICKS[7:0] - 8'h01)
    else $error("init too short");
endmodule : lp_link_checker

/* File: verification/low_power_mode_controller_tb_top.sv */
// self-checking bench for both ends of the low-power link
`timescale 1ns/100ps
module low_power_mode_controller_tb_top;
  import lp_pkg::*;
  logic clock, reset, read, write, waitrequest, cpu_int_masked, periph_irq, init_n, hw_n, nmi_n;
  logic cpu_halt, periph_run, osc_run, bus_hiz, chip_reset, reset_exception, int_exception;
  logic phi_tick, clock_stable, bus_hold, serial_adc_init;
  logic [5:0]  address;
  logic [31:0] writedata, readdata, q;
  logic [15:0] irq_n, module_halt, int_on;
  logic [7:0]  ext_halt;
  logic [2:0]  busy;
  int          fail_count, comparisons, n;
  lp_link_if link();
  lp_device #(.SETTLE_BASE_TICKS(16'h0002)) i_lp_device (.clock(clock), .reset(reset), .link(link),
    .external_int_lines_n(irq_n), .nmi_pin_n(nmi_n), .external_init_pin_n(init_n), .hw_standby_pin_n(hw_n),
    .periph_irq(periph_irq), .module_busy(busy), .cpu_halt(cpu_halt), .periph_run(periph_run), .phi_tick(phi_tick),
    .osc_run(osc_run), .clock_stable(clock_stable), .bus_hiz(bus_hiz), .bus_hold(bus_hold),
    .serial_adc_init(serial_adc_init), .module_halt(module_halt), .ext_module_halt(ext_halt), .chip_reset(chip_reset),
    .reset_exception(reset_exception), .int_exception(int_exception));
  lp_cpu_port i_lp_cpu_port (.clock(clock), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .cpu_int_masked(cpu_int_masked),
    .module_int_on(int_on), .module_busy(busy), .link(link));
  lp_link_checker i_lp_link_checker (.clock(clock), .reset(reset), .sleep_req(link.sleep_req),
    .reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .irq_enable(link.irq_enable), .cpu_int_masked(link.cpu_int_masked), .mode(link.mode));
  // ==========================================================
  // shared tasks
  // ==========================================================
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk
  // request held until waitrequest is seen low at a falling edge, then released after the next rising edge
  task av(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    // a fresh edge first, so a release and the next request never share a time step
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin @(negedge clock); k++; end while (waitrequest !== 1'b0);
    @(posedge clock);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    chk("bus wait states", (w || a >= AV_DEV_LIMIT) ? 2 : 4, k);
  endtask : av
  task rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    av(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd
  task wait_pulse(input bit rst);
    n = 0;
    do begin @(negedge clock); n++; end while ((rst ? reset_exception : int_exception) !== 1'b1 && n < 2000);
    @(posedge clock);
    chk("exception pulse", 1, n < 2000);
  endtask : wait_pulse
  // ==========================================================
  // scenarios
  // ==========================================================
  task t_reset;
    rd(AV_STATUS, 32'h0, "status after reset");
    rd(6'h00, 32'h40, "standby ctrl reset");
    chk("phi_tick", 1, phi_tick);
  endtask : t_reset
  task t_sleep;
    av(1'b1, AV_SLEEP_CMD, 32'h0);
    cpu_int_masked <= 1'b1;
    periph_irq <= 1'b1;
    repeat (10) @(negedge clock);
    chk("cpu_halt", 1, cpu_halt);
    chk("periph_run", 1, periph_run);
    chk("masked sleep", ST_SLEEP, link.mode);
    @(posedge clock);
    cpu_int_masked <= 1'b0;
    wait_pulse(1'b0);
    periph_irq <= 1'b0;
    @(negedge clock);
    chk("cpu resumed", 0, cpu_halt);
  endtask : t_sleep
  task t_hw_standby_pin;
    av(1'b1, 6'h00, 32'h80);
    av(1'b1, 6'h04, 32'h1);
    av(1'b1, AV_SLEEP_CMD, 32'h0);
    irq_n <= 16'hfffe;
    repeat (12) @(negedge clock);
    chk("osc stopped", 0, osc_run);
    chk("periph stopped", 0, periph_run);
    chk("bus float", 1, bus_hiz);
    chk("clock_stable", 0, clock_stable);
    chk("serial_adc_init", 1, serial_adc_init);
    chk("disabled line", ST_STANDBY, link.mode);
    @(posedge clock);
    av(1'b1, AV_IRQ_ENABLE, 32'h1);
    wait_pulse(1'b0);
    irq_n <= 16'hffff;
    @(negedge clock);
    chk("osc back", 1, osc_run);
    chk("bus driven", 0, bus_hiz);
    rd(6'h04, 32'h1, "wake_en kept");
    av(1'b1, 6'h00, 32'hc0);
    av(1'b1, AV_SLEEP_CMD, 32'h0);
    repeat (6) @(negedge clock);
    chk("bus held", 1, bus_hold);
    chk("bus not floated", 0, bus_hiz);
    @(posedge clock);
    nmi_n <= 1'b0;
    wait_pulse(1'b0);
    nmi_n <= 1'b1;
  endtask : t_hw_standby_pin
  task t_init;
    init_n <= 1'b0;
    repeat (6) @(negedge clock);
    chk("chip_reset", 1, chip_reset);
    @(posedge clock);
    init_n <= 1'b1;
    wait_pulse(1'b1);
    rd(6'h00, 32'h40, "ctrl after init");
  endtask : t_init
  task t_hw;
    av(1'b1, AV_SLEEP_CMD, 32'h0);
    hw_n <= 1'b0;
    repeat (8) @(negedge clock);
    chk("hw standby", ST_HWSTBY, link.mode);
    chk("hw bus float", 1, bus_hiz);
    @(posedge clock);
    hw_n <= 1'b1;
    wait_pulse(1'b1);
  endtask : t_hw
  task t_halt;
    busy <= 3'b010;
    av(1'b1, 6'h08, 32'h2000);
    rd(6'h08, 32'h0, "halt refused");
    rd(AV_STATUS, 32'h8, "refused flag");
    busy <= 3'b000;
    av(1'b1, 6'h08, 32'h2000);
    rd(6'h08, 32'h2000, "halt accepted");
    chk("module_halt", 32'h2000, {16'h0, module_halt});
    int_on <= 16'h0001;
    av(1'b1, 6'h08, 32'h2001);
    rd(6'h08, 32'h2000, "halt int refused");
    av(1'b1, 6'h0c, 32'h1);
    rd(6'h0c, 32'h1, "ext halt accepted");
    chk("ext_module_halt", 32'h1, {24'h0, ext_halt});
    av(1'b1, 6'h10, 32'h3);
    rd(6'h10, 32'h0, "divider refused");
    av(1'b1, 6'h10, 32'h2);
    rd(6'h10, 32'h2, "divider accepted");
  endtask : t_halt
  task close_out;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  // ==========================================================
  // clock, watchdog, sequence
  // ==========================================================
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial
  begin
    #200000;
    fail_count++;
    close_out;
  end
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0;
    cpu_int_masked = 1'b0;
    periph_irq = 1'b0;
    init_n = 1'b1;
    hw_n = 1'b1;
    nmi_n = 1'b1;
    irq_n = 16'hffff;
    busy = 3'b000;
    int_on = 16'h0000;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset;
    t_sleep;
    t_hw_standby_pin;
    t_init;
    t_hw;
    t_halt;
    close_out;
  end
endmodule : low_power_mode_controller_tb_top
